/* File: rtl/spfe_map.svh */
// Constants of the serial paged flash front end
`ifndef SPFE_MAP_SVH
`define SPFE_MAP_SVH
// --------------------------------------------------------------
// Instruction codes
// --------------------------------------------------------------
`define SPFE_OP_WRITE_ENABLE_CMD_C    8'h06
`define SPFE_OP_WRITE_DISABLE_CMD_C    8'h04
`define SPFE_OP_PWRITE_C  8'h0A
`define SPFE_OP_PPROG_C   8'h02
`define SPFE_OP_PERASE_C  8'hDB
`define SPFE_OP_SERASE_C  8'hD8
// --------------------------------------------------------------
// Array geometry
// --------------------------------------------------------------
`define SPFE_PAGE_BYTES   256
`define SPFE_PAGE_LAST    8'hFF
`define SPFE_ERASED_BYTE  8'hFF
`define SPFE_PAGE_MSB     16
`define SPFE_PAGE_LSB     8
`define SPFE_SECTOR_BIT   16
// --------------------------------------------------------------
// Bit counting and internal cycle timing
// --------------------------------------------------------------
`define SPFE_BITS_BYTE    3'h7
`define SPFE_ADDR_BYTES   2'h3
`define SPFE_ERASE_CYC    16'h0400
`define SPFE_PROG_CYC     16'h0100
`endif

/* File: rtl/spfe_pkg.sv */
// Types of the serial paged flash front end
package spfe_pkg;
    typedef logic [8:0]  spfe_page_t;    // Page index 0..511
    typedef logic [7:0]  spfe_byte_t;    // One data byte
    typedef logic [23:0] spfe_addr_t;    // Full 24-bit address
    // Serial front end phase within one selection
    typedef enum logic [2:0] {
        SPFE_PH_OPC  = 3'b000,
        SPFE_PH_ADDR = 3'b001,
        SPFE_PH_DATA = 3'b010,
        SPFE_PH_SKIP = 3'b011
    } spfe_phase_e;
    // Internal array cycle
    typedef enum logic [2:0] {
        SPFE_AR_IDLE  = 3'b000,
        SPFE_AR_MERGE = 3'b001,
        SPFE_AR_ERASE = 3'b010,
        SPFE_AR_PROG  = 3'b011,
        SPFE_AR_SECT  = 3'b100
    } spfe_array_e;
endpackage

/* File: rtl/spfe_sync_if.sv */
// Interface carrying synchronised pin levels into the core
`timescale 1ns/10ps
interface spfe_sync_if;
    logic sck;        // Synchronised serial clock
    logic cs_n;       // Synchronised chip select
    logic mosi;       // Synchronised serial data in
    logic wp_n;       // Synchronised write protect
    logic rst_n;      // Synchronised hardware reset
    modport src (output sck, cs_n, mosi, wp_n, rst_n);
    modport dst (input  sck, cs_n, mosi, wp_n, rst_n);
endinterface

/* File: rtl/spfe_pin_sync.sv */
// Two-stage synchroniser for the five link input pins
`timescale 1ns/10ps
module spfe_pin_sync (
    input  wire logic i_clk_sys,
    input  wire logic i_nrst,
    input  wire logic i_ce,
    input  wire logic [4:0] i_pins,
    spfe_sync_if.src  o_sync
);
    logic [4:0] meta_ff;     // First stage, read only by second stage
    logic [4:0] sync_ff;     // Second stage
    logic [4:0] nxt_meta;
    logic [4:0] nxt_sync;

    // ------------------------------------------------------------
    // Next values
    // ------------------------------------------------------------
    always_comb begin
        nxt_meta = meta_ff;
        nxt_sync = sync_ff;
        if (!i_nrst) begin
            // Idle levels: clock low, deselected, unprotected, reset released
            nxt_meta = 5'h1E;
            nxt_sync = 5'h1E;
        end else if (i_ce) begin
            nxt_meta = i_pins;
            nxt_sync = meta_ff;
        end
    end

    // Registers only
    always_ff @(posedge i_clk_sys) begin
        meta_ff <= nxt_meta;
        sync_ff <= nxt_sync;
    end

    assign o_sync.sck   = sync_ff[0];
    assign o_sync.cs_n  = sync_ff[1];
    assign o_sync.mosi  = sync_ff[2];
    assign o_sync.wp_n  = sync_ff[3];
    assign o_sync.rst_n = sync_ff[4];
endmodule

/* File: rtl/spfe_top.sv */
// Serial front end and page buffer control of a paged flash memory
`timescale 1ns/10ps
`include "spfe_map.svh"
module spfe_top
    import spfe_pkg::*;
(
    input  wire logic i_clk_sys,        // System clock, 100 MHz
    input  wire logic i_nrst,           // Synchronous reset, active low
    input  wire logic i_ce,             // Clock enable, freezes all state
    input  wire logic i_sck,            // Serial clock pin
    input  wire logic i_cs_n,           // Chip select pin, active low
    input  wire logic i_mosi,           // Serial data in pin
    input  wire logic i_wp_n,           // Write protect pin, active low
    input  wire logic i_hw_rst_n,       // Hardware reset pin, active low
    output logic      o_miso,           // Serial data out
    output logic      o_miso_oe_n,      // Output enable, low while driving
    output logic      o_busy,           // Internal cycle in progress
    output logic      o_wel,            // Write enable latch
    output logic      o_active          // Active power mode
);
    import spfe_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    spfe_sync_if sy ();
    spfe_pin_sync u_sync (
        .i_clk_sys (i_clk_sys),
        .i_nrst    (i_nrst),
        .i_ce      (i_ce),
        .i_pins    ({i_hw_rst_n, i_wp_n, i_mosi, i_cs_n, i_sck}),
        .o_sync    (sy.src)
    );

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    spfe_byte_t  mem_ff [0:511][0:255];   // Array model, flip-flops
    spfe_byte_t  buf_ff [0:255];          // Page buffer
    logic [255:0] touched_ff;             // Buffer bytes supplied by master
    logic        sck_d_ff, cs_d_ff;       // Previous synchronised levels
    logic        armed_ff;                // Chip select fall seen since reset
    spfe_phase_e ph_ff;                   // Serial phase
    logic [2:0]  bit_ff;                  // Bit within byte
    spfe_byte_t  sh_ff;                   // Input shift register
    spfe_byte_t  opc_ff;                  // Latched opcode
    logic [1:0]  abyte_ff;                // Address bytes received
    spfe_addr_t  addr_ff;                 // Latched address
    spfe_byte_t  ptr_ff;                  // Buffer byte position
    logic        gotdata_ff;              // At least one data byte
    logic        wel_ff;                  // Write enable latch
    spfe_array_e ar_ff;                   // Internal cycle state
    logic [15:0] tmr_ff;                  // Internal cycle timer
    spfe_page_t  pg_ff;                   // Page under internal cycle
    logic [8:0]  idx_ff;                  // Byte index for merge
    logic        miso_ff, oe_n_ff, busy_ff, act_ff;

    // Edge detection on second synchroniser stage
    logic sck_rise, sck_fall, cs_fall, cs_rise;
    assign sck_rise = sy.sck & ~sck_d_ff;
    assign sck_fall = ~sy.sck & sck_d_ff;
    assign cs_fall  = ~sy.cs_n & cs_d_ff;
    assign cs_rise  = sy.cs_n & ~cs_d_ff;

    // Pages 0..255 are guarded while write protect is low
    function automatic logic prot(input spfe_page_t p, input logic wp_n);
        prot = ~wp_n & ~p[8];
    endfunction

    // ------------------------------------------------------------
    // Serial front end and latch, next values
    // ------------------------------------------------------------
    spfe_phase_e nxt_ph;
    logic [2:0]  nxt_bit;
    spfe_byte_t  nxt_sh, nxt_opc, nxt_ptr;
    logic [1:0]  nxt_abyte;
    spfe_addr_t  nxt_addr;
    logic        nxt_got, nxt_wel, nxt_armed;
    logic        start_pw, start_pp, start_pe, start_se;
    spfe_byte_t  rx;
    always_comb begin
        nxt_ph = ph_ff;  nxt_bit = bit_ff;  nxt_sh = sh_ff;
        nxt_opc = opc_ff; nxt_ptr = ptr_ff; nxt_abyte = abyte_ff;
        nxt_addr = addr_ff; nxt_got = gotdata_ff; nxt_wel = wel_ff;
        nxt_armed = armed_ff;
        start_pw = 1'b0; start_pp = 1'b0; start_pe = 1'b0; start_se = 1'b0;
        rx = {sh_ff[6:0], sy.mosi};
        if (cs_fall) begin
            // Fresh selection; nothing decoded before the first fall
            nxt_armed = 1'b1;
            nxt_ph = SPFE_PH_OPC;
            nxt_bit = 3'h0;
            nxt_abyte = 2'h0;
            nxt_got = 1'b0;
        end else if (!sy.cs_n && armed_ff && sck_rise) begin
            nxt_sh = rx;
            nxt_bit = bit_ff + 3'h1;
            if (bit_ff == `SPFE_BITS_BYTE) begin
                case (ph_ff)
                    SPFE_PH_OPC: begin
                        nxt_opc = rx;
                        nxt_ph = SPFE_PH_ADDR;
                    end
                    SPFE_PH_ADDR: begin
                        nxt_addr = {addr_ff[15:0], rx};
                        nxt_abyte = abyte_ff + 2'h1;
                        nxt_ptr = rx;
                        if (abyte_ff == (`SPFE_ADDR_BYTES - 2'h1))
                            nxt_ph = SPFE_PH_DATA;
                    end
                    SPFE_PH_DATA: begin
                        nxt_got = 1'b1;
                        nxt_ptr = ptr_ff + 8'h01;
                    end
                    default: begin
                        nxt_ph = SPFE_PH_SKIP;
                    end
                endcase
            end
        end else if (cs_rise && armed_ff && bit_ff == 3'h0 && sy.rst_n) begin
            // Only byte-aligned sequences are executed
            if (opc_ff == `SPFE_OP_WRITE_ENABLE_CMD_C && ph_ff == SPFE_PH_ADDR &&
                abyte_ff == 2'h0)
                nxt_wel = 1'b1;
            else if (opc_ff == `SPFE_OP_WRITE_DISABLE_CMD_C && ph_ff == SPFE_PH_ADDR &&
                     abyte_ff == 2'h0)
                nxt_wel = 1'b0;
            else if (wel_ff && !busy_ff && !prot(addr_ff[16:8], sy.wp_n)) begin
                start_pw = (opc_ff == `SPFE_OP_PWRITE_C) && gotdata_ff;
                start_pp = (opc_ff == `SPFE_OP_PPROG_C) && gotdata_ff;
                start_pe = (opc_ff == `SPFE_OP_PERASE_C) && ph_ff == SPFE_PH_DATA
                           && !gotdata_ff;
                start_se = (opc_ff == `SPFE_OP_SERASE_C) && ph_ff == SPFE_PH_DATA
                           && !gotdata_ff;
            end
        end
        if (!sy.rst_n && !busy_ff)
            nxt_wel = 1'b0;
        else if (busy_ff && ar_ff == SPFE_AR_IDLE)
            nxt_wel = 1'b0;
    end

    // ------------------------------------------------------------
    // Internal cycle, next values
    // ------------------------------------------------------------
    spfe_array_e nxt_ar;
    logic [15:0] nxt_tmr;
    spfe_page_t  nxt_pg;
    logic [8:0]  nxt_idx;
    logic        nxt_busy;
    always_comb begin
        nxt_ar = ar_ff; nxt_tmr = tmr_ff; nxt_pg = pg_ff; nxt_idx = idx_ff;
        nxt_busy = busy_ff;
        case (ar_ff)
            SPFE_AR_IDLE: begin
                nxt_busy = 1'b0;
                nxt_idx = 9'h000;
                nxt_pg = addr_ff[16:8];
                if (start_pw) begin
                    nxt_ar = SPFE_AR_MERGE;
                    nxt_busy = 1'b1;
                end else if (start_pp) begin
                    nxt_ar = SPFE_AR_PROG;
                    nxt_tmr = `SPFE_PROG_CYC;
                    nxt_busy = 1'b1;
                end else if (start_pe) begin
                    nxt_ar = SPFE_AR_ERASE;
                    nxt_tmr = `SPFE_ERASE_CYC;
                    nxt_busy = 1'b1;
                end else if (start_se) begin
                    nxt_ar = SPFE_AR_SECT;
                    nxt_tmr = `SPFE_ERASE_CYC;
                    nxt_busy = 1'b1;
                end
            end
            SPFE_AR_MERGE: begin
                // One buffer byte per cycle
                nxt_idx = idx_ff + 9'h001;
                if (idx_ff[7:0] == `SPFE_PAGE_LAST) begin
                    nxt_ar = SPFE_AR_ERASE;
                    nxt_tmr = `SPFE_ERASE_CYC;
                end
            end
            SPFE_AR_PROG: begin
                nxt_tmr = tmr_ff - 16'h0001;
                if (tmr_ff == 16'h0001)
                    nxt_ar = SPFE_AR_IDLE;
            end
            default: begin
                // Page or sector erase wait; page write continues to program
                nxt_tmr = tmr_ff - 16'h0001;
                if (tmr_ff == 16'h0001) begin
                    if (opc_ff == `SPFE_OP_PWRITE_C) begin
                        nxt_ar = SPFE_AR_PROG;
                        nxt_tmr = `SPFE_PROG_CYC;
                    end else begin
                        nxt_ar = SPFE_AR_IDLE;
                    end
                end
            end
        endcase
    end

    // ------------------------------------------------------------
    // Registers; reset pin never touches the internal cycle
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            sck_d_ff <= 1'b0;  cs_d_ff <= 1'b1;  armed_ff <= 1'b0;
            ph_ff <= SPFE_PH_SKIP; bit_ff <= 3'h0; sh_ff <= 8'h00;
            opc_ff <= 8'h00; abyte_ff <= 2'h0; addr_ff <= 24'h000000;
            ptr_ff <= 8'h00; gotdata_ff <= 1'b0; wel_ff <= 1'b0;
            ar_ff <= SPFE_AR_IDLE; tmr_ff <= 16'h0000; pg_ff <= 9'h000;
            idx_ff <= 9'h000; busy_ff <= 1'b0;
            miso_ff <= 1'b0; oe_n_ff <= 1'b1; act_ff <= 1'b0;
            touched_ff <= '0;
        end else if (i_ce) begin
            sck_d_ff <= sy.sck;  cs_d_ff <= sy.cs_n;  armed_ff <= nxt_armed;
            ph_ff <= nxt_ph; bit_ff <= nxt_bit; sh_ff <= nxt_sh;
            opc_ff <= (ar_ff != SPFE_AR_IDLE) ? opc_ff : nxt_opc;
            abyte_ff <= nxt_abyte; addr_ff <= nxt_addr; ptr_ff <= nxt_ptr;
            gotdata_ff <= nxt_got; wel_ff <= nxt_wel;
            ar_ff <= nxt_ar; tmr_ff <= nxt_tmr; pg_ff <= nxt_pg;
            idx_ff <= nxt_idx; busy_ff <= nxt_busy;
            // No read path: output stays released, low level on falls
            if (sck_fall) miso_ff <= 1'b0;
            oe_n_ff <= 1'b1;
            act_ff <= ~sy.cs_n | busy_ff;
            if (cs_fall && ar_ff == SPFE_AR_IDLE)
                touched_ff <= '0;
            if (ph_ff == SPFE_PH_DATA && sck_rise && bit_ff == `SPFE_BITS_BYTE
                && !sy.cs_n && !busy_ff) begin
                buf_ff[ptr_ff] <= {sh_ff[6:0], sy.mosi};
                touched_ff[ptr_ff] <= 1'b1;
            end
            if (ar_ff == SPFE_AR_MERGE && !touched_ff[idx_ff[7:0]])
                buf_ff[idx_ff[7:0]] <= mem_ff[pg_ff][idx_ff[7:0]];
            if (ar_ff == SPFE_AR_IDLE && start_pp)
                for (int i = 0; i < `SPFE_PAGE_BYTES; i++)
                    if (!touched_ff[i]) buf_ff[i] <= `SPFE_ERASED_BYTE;
            if (ar_ff != SPFE_AR_IDLE && nxt_tmr == 16'h0001 && tmr_ff == 16'h0002) begin
                for (int i = 0; i < `SPFE_PAGE_BYTES; i++) begin
                    if (ar_ff == SPFE_AR_PROG)
                        mem_ff[pg_ff][i] <= mem_ff[pg_ff][i] & buf_ff[i];
                    else if (ar_ff == SPFE_AR_ERASE)
                        mem_ff[pg_ff][i] <= `SPFE_ERASED_BYTE;
                end
            end
            if (ar_ff == SPFE_AR_SECT && tmr_ff == 16'h0002)
                for (int p = 0; p < 256; p++)
                    for (int i = 0; i < `SPFE_PAGE_BYTES; i++)
                        mem_ff[{pg_ff[8], p[7:0]}][i] <= `SPFE_ERASED_BYTE;
        end
    end

    assign o_miso      = miso_ff;
    assign o_miso_oe_n = oe_n_ff;
    assign o_busy      = busy_ff;
    assign o_wel       = wel_ff;
    assign o_active    = act_ff;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_prot_guard: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (i_ce && prot(addr_ff[16:8], sy.wp_n) && ar_ff == SPFE_AR_IDLE) |=> !busy_ff)
        else $error("Protected page started a cycle");
    a_pw_order: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (ar_ff == SPFE_AR_MERGE && nxt_ar != SPFE_AR_MERGE && i_ce) |=> ar_ff == SPFE_AR_ERASE)
        else $error("Merge not followed by erase");
    a_miso_off: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        sy.cs_n |-> ##1 o_miso_oe_n)
        else $error("Output driven while deselected");
    a_busy_sel: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (i_ce && !sy.cs_n) |=> o_active)
        else $error("Selected device not active");
    a_wel_clear: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        $fell(busy_ff) |-> !wel_ff)
        else $error("Latch set after cycle end");
    a_cycle_hold: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (busy_ff && !sy.rst_n && i_ce && ar_ff == SPFE_AR_PROG && tmr_ff > 16'h0001)
        |=> busy_ff)
        else $error("Reset disturbed a cycle");
    a_no_start_busy: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (ar_ff != SPFE_AR_IDLE && i_ce) |=> $stable(pg_ff))
        else $error("Start while busy");
    a_arm_first: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        !armed_ff |-> !busy_ff)
        else $error("Cycle before first select");
endmodule

/* File: verification/spfe_spi_master.sv */
// Behavioural serial bus master that drives the front end pins
`timescale 1ns/10ps
module spfe_spi_master (
    output logic o_sck,     // Serial clock, idles at the mode level
    output logic o_cs_n,    // Chip select, active low
    output logic o_mosi,    // Serial data towards the device
    output logic o_done     // Pulse once a frame has settled
);
    // ----------------------------------------------------------
    // Idle state at time zero
    // ----------------------------------------------------------
    initial begin
        o_sck = 1'b0;
        o_cs_n = 1'b1;
        o_mosi = 1'b0;
        o_done = 1'b0;
    end

    // ----------------------------------------------------------
    // One framed transfer
    // ----------------------------------------------------------
    // Sends the bytes of q, leaving out the last drop bits, at a 125 ns period
    task automatic frame(input logic cpol, input logic [7:0] q[$], input int drop);
        int n;
        n = q.size() * 8 - drop;
        o_sck <= cpol;
        #100 o_cs_n <= 1'b0;
        for (int i = 0; i < n; i++) begin
            #31.25 o_sck <= 1'b0;
            o_mosi <= q[i / 8][7 - i % 8];
            #62.5 o_sck <= 1'b1;
            #31.25;
        end
        #31.25 o_sck <= cpol;
        #31.25 o_cs_n <= 1'b1;
        // Released line shows the inverse so a stale bit is never reused
        o_mosi <= ~o_mosi;
        #300 o_done <= 1'b1;
        #10 o_done <= 1'b0;
    endtask
endmodule

/* File: verification/spfe_top_test.sv */
// Self-checking bench for the serial paged flash front end
`timescale 1ns/10ps
`include "spfe_map.svh"
module spfe_top_test;
    import spfe_pkg::*;
    typedef logic [7:0] spfe_bq_t[$];   // Byte queue for one frame
    logic       clk_sys = 1'b0;         // 100 MHz system clock
    logic       nrst, ce, wp_n, hw_rst_n;
    logic       sck, cs_n, mosi, done;  // Driven by the master model
    logic       miso, miso_oe_n, busy, write_enable_latch, active;
    logic [1:0] exp_q[$];               // Expected busy and latch per frame
    logic [1:0] exp_now;                // Note taken off the queue
    spfe_bq_t   q;                      // Frame under construction
    spfe_page_t pg;                     // Random target page
    spfe_byte_t off;                    // Random start offset
    int         fail_count = 0;
    int         checks_done = 0;
    int         cycles = 0;
    int         busy_len = 0;           // Cycles of the running cycle
    int         last_len = 0;           // Length of the last finished cycle

    always #5 clk_sys = ~clk_sys;

    spfe_spi_master m (.o_sck(sck), .o_cs_n(cs_n), .o_mosi(mosi), .o_done(done));
    spfe_top dut (.i_clk_sys(clk_sys), .i_nrst(nrst), .i_ce(ce), .i_sck(sck),
        .i_cs_n(cs_n), .i_mosi(mosi), .i_wp_n(wp_n), .i_hw_rst_n(hw_rst_n),
        .o_miso(miso), .o_miso_oe_n(miso_oe_n), .o_busy(busy), .o_wel(write_enable_latch),
        .o_active(active));

    // ----------------------------------------------------------
    // Checking helpers
    // ----------------------------------------------------------
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %0h seen %0h", name, exp, got);
        end
    endtask

    task automatic wrap_up();
        if (fail_count == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Opcode plus three address bytes, most significant first
    function automatic spfe_bq_t hdr(input spfe_byte_t op, input spfe_page_t p,
                                     input spfe_byte_t o);
        return '{op, {7'h00, p[8]}, p[7:0], o};
    endfunction

    // Notes the expected outcome, then sends the frame
    task automatic txn(input logic cpol, input spfe_bq_t b, input int drop,
                       input logic [1:0] exp);
        exp_q.push_back(exp);
        m.frame(cpol, b, drop);
    endtask

    // Waits, bounded, for the internal cycle to end and checks its length
    task automatic idle_len(input int exp);
        for (int i = 0; i < 4000 && busy !== 1'b0; i++) begin
            @(posedge clk_sys);
        end
        repeat (3) @(posedge clk_sys);
        chk("cycle length", 16'h1, 16'(last_len >= exp && last_len <= exp + 8));
        chk("latch after cycle", 16'h0, write_enable_latch);
    endtask

    // ----------------------------------------------------------
    // Result watcher and cycle-length counter
    // ----------------------------------------------------------
    // Frames settle after select rises, so active must follow busy alone
    always @(posedge done) begin
        exp_now = exp_q.pop_front();
        chk("busy and latch", exp_now, {busy, write_enable_latch});
        chk("output enable", 16'h1, miso_oe_n);
        chk("serial out", 16'h0, miso);
        chk("active", exp_now[1], active);
    end

    always @(posedge clk_sys) begin
        busy_len <= (busy === 1'b1) ? busy_len + 1 : 0;
        if (busy !== 1'b1 && busy_len != 0) begin
            last_len <= busy_len;
        end
        cycles <= cycles + 1;
        // Longest path is a full page write frame, about 26000 cycles
        if (cycles == 90000) begin
            fail_count++;
            wrap_up();
        end
    end

    // ----------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------
    initial begin
        void'($urandom(43837));
        nrst = 1'b0;
        ce = 1'b1;
        wp_n = 1'b1;
        hw_rst_n = 1'b1;
        repeat (5) @(posedge clk_sys);
        nrst <= 1'b1;
        repeat (5) @(posedge clk_sys);
        txn(1'b0, '{`SPFE_OP_WRITE_ENABLE_CMD_C}, 1, 2'b00);
        txn(1'b0, '{`SPFE_OP_WRITE_ENABLE_CMD_C}, 0, 2'b01);
        txn(1'b1, '{`SPFE_OP_WRITE_DISABLE_CMD_C}, 0, 2'b00);
        @(posedge clk_sys) hw_rst_n <= 1'b0;
        txn(1'b1, '{`SPFE_OP_WRITE_ENABLE_CMD_C}, 0, 2'b00);
        @(posedge clk_sys) hw_rst_n <= 1'b1;
        wp_n <= 1'b0;
        // Guarded lower sector refuses an erase while protection is on
        txn(1'b0, '{`SPFE_OP_WRITE_ENABLE_CMD_C}, 0, 2'b01);
        pg = 9'($urandom_range(255));
        txn(1'b1, hdr(`SPFE_OP_PERASE_C, pg, 8'h00), 0, 2'b01);
        // Page write in the upper sector with random data, kept inside the page
        pg = 9'h100 | 9'($urandom_range(255));
        off = 8'($urandom);
        q = hdr(`SPFE_OP_PWRITE_C, pg, off);
        for (int i = $urandom_range(`SPFE_PAGE_BYTES - off, 1); i > 0; i--) begin
            q.push_back(8'($urandom));
        end
        txn(1'b0, q, 0, 2'b11);
        @(posedge clk_sys) hw_rst_n <= 1'b0;
        txn(1'b1, hdr(`SPFE_OP_PERASE_C, pg, 8'h00), 0, 2'b11);
        @(posedge clk_sys) hw_rst_n <= 1'b1;
        idle_len(`SPFE_PAGE_BYTES + `SPFE_ERASE_CYC + `SPFE_PROG_CYC);
        // Protection lifted: the lowest page may now be erased
        @(posedge clk_sys) wp_n <= 1'b1;
        txn(1'b1, '{`SPFE_OP_WRITE_ENABLE_CMD_C}, 0, 2'b01);
        txn(1'b0, hdr(`SPFE_OP_PERASE_C, 9'h000, 8'h00), 0, 2'b11);
        idle_len(`SPFE_ERASE_CYC);
        txn(1'b0, '{`SPFE_OP_WRITE_ENABLE_CMD_C}, 0, 2'b01);
        txn(1'b1, hdr(`SPFE_OP_SERASE_C, 9'h1FF, 8'h00), 3, 2'b01);
        txn(1'b1, hdr(`SPFE_OP_SERASE_C, 9'h1FF, 8'h00), 0, 2'b11);
        idle_len(`SPFE_ERASE_CYC);
        // Page program of a single byte at the very end of a page
        txn(1'b0, '{`SPFE_OP_WRITE_ENABLE_CMD_C}, 0, 2'b01);
        q = hdr(`SPFE_OP_PPROG_C, 9'($urandom_range(511)), `SPFE_PAGE_LAST);
        q.push_back(8'($urandom));
        txn(1'b0, q, 0, 2'b11);
        for (int i = 0; i < 4000 && busy !== 1'b0; i++) begin
            @(posedge clk_sys);
        end
        repeat (3) @(posedge clk_sys);
        chk("latch after program", 16'h0, write_enable_latch);
        wrap_up();
    end
endmodule
